// [logic/an_status_pkg.sv]
// Shared constants of the auto-negotiation partner status register bank.
// Assumes a 32-bit APB with 12 address bits and word-aligned registers.
package an_status_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0]  PARTNER_IDX    = 10'h005;
	localparam logic [9:0]  EXPANSION_IDX  = 10'h006;
	localparam logic [9:0]  OVERRIDE_IDX   = 10'h010;
	localparam logic [9:0]  IRQ_STATUS_IDX = 10'h020;
	localparam logic [9:0]  IRQ_MASK_IDX   = 10'h021;

	localparam int          ADDR_W         = 12;
	localparam int          WORD_W         = 16;

	// Partner ability word field positions.
	localparam int          PA_NEXT_PAGE   = 15;
	localparam int          PA_ACK         = 14;
	localparam int          PA_REM_FAULT   = 13;
	localparam int          PA_TAF_HI      = 12;
	localparam int          PA_TAF_LO      = 5;
	localparam int          PA_SEL_HI      = 4;
	localparam int          PA_SEL_LO      = 0;
	// Reserved 5.12:10 read as zero; selector 5.3:0 is override-writable.
	localparam logic [15:0] PA_READ_MASK   = 16'hE3FF;
	localparam logic [15:0] PA_CW_MASK     = 16'h000F;
	localparam logic [15:0] PA_RESET       = 16'h0000;
	localparam logic [4:0]  SEL_IEEE_8023  = 5'h01;
	localparam logic [4:0]  SEL_IEEE_8029  = 5'h02;

	// Expansion register field positions.
	localparam int          EX_PD_FAULT    = 4;
	localparam int          EX_LP_NP_ABLE  = 3;
	localparam int          EX_NP_ABLE     = 2;
	localparam int          EX_PAGE_RX     = 1;
	localparam int          EX_LP_AN_ABLE  = 0;
	localparam int          EX_RSVD_LO     = 5;
	localparam int          EX_RSVD_W      = 11;
	localparam logic [15:0] EX_RESET       = 16'h0004;
	localparam logic [10:0] EX_RSVD_RESET  = 11'h000;

	// Command override register.
	localparam int          OVR_BIT        = 15;
	localparam logic [15:0] OVR_RESET      = 16'h0000;

	// Interrupt status and mask layout.
	localparam int          IRQ_W          = 3;
	localparam int          IRQ_PAGE_RX    = 0;
	localparam int          IRQ_PD_FAULT   = 1;
	localparam int          IRQ_REM_FAULT  = 2;
	localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;

	// Turns an APB byte address into a register index.
	function automatic logic [9:0] byte_to_index(
		input logic [ADDR_W-1:0] addr
	);
		byte_to_index = addr[ADDR_W-1:2];
	endfunction : byte_to_index

	// True when the two low address bits select a whole aligned word.
	function automatic logic is_aligned(input logic [ADDR_W-1:0] addr);
		is_aligned = (addr[1:0] == 2'h0);
	endfunction : is_aligned

endpackage : an_status_pkg

// [logic/latch_high_flag.sv]
// One latching-high status bit.
// Assumes set and clear are single-cycle strobes synchronous to pclk.
module latch_high_flag (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic set,
	input  wire logic clear,
	// State
	output logic      q
);

	// A set arriving with the clear wins, so no event is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clear) begin
			q <= 1'b0;
		end
	end

endmodule : latch_high_flag

// [logic/page_capture.sv]
// Holding register for the last link code word taken from the partner.
// Assumes page_valid is a one-cycle strobe with page_word valid alongside.
module page_capture (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Received page
	input  wire logic        page_valid,
	input  wire logic [15:0] page_word,
	// Override write from management
	input  wire logic        cw_we,
	input  wire logic [15:0] cw_data,
	// Stored word
	output logic      [15:0] word
);

	// A received page wins over a management write in the same cycle,
	// because the partner's word is the truth the register must show.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word <= an_status_pkg::PA_RESET;
		end else if (page_valid) begin
			word <= page_word; // (R4)
		end else if (cw_we) begin
			word <= (word & ~an_status_pkg::PA_CW_MASK)
				| (cw_data & an_status_pkg::PA_CW_MASK); // (R9)
		end
	end

endmodule : page_capture

// [logic/autoneg_partner_status_regs.sv]
// Partner ability and expansion status registers behind an APB slave.
// Assumes the auto-negotiation core drives its strobes on pclk and that
// APB and that core share the one clock.
//
// Added by the designer: the APB register port.

// How it works
// (R1) Bit 5.15 shows partner next-page flag.
// (R2) Bit 5.14 shows partner acknowledge.
// (R3) Bit 5.13 shows partner remote fault.
// (R4) Bits 5.12:5 copy partner technology abilities; the read mask zeroes 5.12:10, so only 5.9:5 show the partner's bits.
// (R5) Reserved bits 5.12:10 always read zero.
// (R6) Software writes default values into reserved bits.
// (R7) Bits 5.4:0 show partner selector code.
// (R8) Reserved bits 6.15:5 always read zero.
// (R9) Protected bits writable only with override set.
// (R10) Parallel detect fault latches 6.4 until read.
// (R11) Bit 6.3 follows partner next-page bit.
// (R12) Bit 6.2 reads one, local next page.
// (R13) New page latches page-received bit 6.1.
// (R14) Reading expansion register clears page-received.
// (R15) Bit 6.0 set while valid bursts arrive.
// (R16) Software trusts partner word after completion.
// (R17) Word and page flag update together.
module autoneg_partner_status_regs (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Auto-negotiation core
	input  wire logic        page_valid,
	input  wire logic [15:0] page_word,
	input  wire logic        pd_fault,
	input  wire logic        flp_valid,
	// Auxiliary controls and interrupt
	output logic      [10:0] aux_reserved,
	output logic             irq
);

	// Bus phase decode.
	logic        setup_phase;
	logic        access_done;
	logic        wr_done;
	logic        rd_done;
	logic [9:0]  acc_idx;
	logic [9:0]  setup_idx;
	logic        setup_hit;

	// Register state.
	logic [15:0] partner_word;
	logic [15:0] override_reg;
	logic [10:0] rsvd_reg;
	logic        lp_an_able_reg;
	logic        page_rx_flag;
	logic        pd_fault_flag;
	logic [2:0]  irq_status;
	logic [2:0]  irq_mask_reg;
	logic        rem_fault_reg;
	logic        override_on;

	// Read values.
	logic [15:0] partner_view;
	logic [15:0] expansion_view;
	logic [31:0] rdata_next;

	// Access strobes and events.
	logic        partner_cw_we;
	logic        rsvd_we;
	logic        override_we;
	logic        mask_we;
	logic        exp_read;
	logic        irq_read;
	logic        rem_fault_rise;
	logic        irq_pending;
	logic [2:0]  irq_events;

	// One decode for every side-effect strobe: the access must complete
	// without an error and address the wanted register.
	function automatic logic strobe_for(
		input logic       done,
		input logic       err,
		input logic [9:0] idx,
		input logic [9:0] want
	);
		strobe_for = done & ~err & (idx == want);
	endfunction : strobe_for

	// True for every register index that the bank answers.
	function automatic logic is_mapped(input logic [9:0] idx);
		case (idx)
			an_status_pkg::PARTNER_IDX:    is_mapped = 1'b1;
			an_status_pkg::EXPANSION_IDX:  is_mapped = 1'b1;
			an_status_pkg::OVERRIDE_IDX:   is_mapped = 1'b1;
			an_status_pkg::IRQ_STATUS_IDX: is_mapped = 1'b1;
			an_status_pkg::IRQ_MASK_IDX:   is_mapped = 1'b1;
			default:                       is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// Places a 16-bit register in the low half of the bus word.
	function automatic logic [31:0] low_half(input logic [15:0] v);
		low_half = {16'h0000, v};
	endfunction : low_half

	// Places a 3-bit interrupt register in the low bits of the bus word.
	function automatic logic [31:0] irq_word(input logic [2:0] v);
		irq_word = {29'h0, v};
	endfunction : irq_word

	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_done     = access_done & pwrite;
	assign rd_done     = access_done & ~pwrite;
	assign acc_idx     = an_status_pkg::byte_to_index(paddr);
	assign setup_idx   = acc_idx;
	assign override_on = override_reg[an_status_pkg::OVR_BIT];

	// Address decode of the setup cycle; misaligned or unknown is an error.
	always_comb begin
		setup_hit = 1'b0;
		if (an_status_pkg::is_aligned(paddr)) begin
			setup_hit = is_mapped(setup_idx);
		end
	end

	// Partner word as software sees it.
	always_comb begin
		partner_view = partner_word
			& an_status_pkg::PA_READ_MASK; // (R5)
	end

	// Expansion register as software sees it.
	// Bit 6.0 is a plain level and drops when the bursts stop.
	always_comb begin
		expansion_view = 16'h0000; // (R8)
		expansion_view[an_status_pkg::EX_PD_FAULT] = pd_fault_flag; // (R10)
		expansion_view[an_status_pkg::EX_LP_NP_ABLE] =
			partner_word[an_status_pkg::PA_NEXT_PAGE]; // (R11)
		expansion_view[an_status_pkg::EX_NP_ABLE] =
			an_status_pkg::EX_RESET[an_status_pkg::EX_NP_ABLE]; // (R12)
		expansion_view[an_status_pkg::EX_PAGE_RX] = page_rx_flag; // (R13)
		expansion_view[an_status_pkg::EX_LP_AN_ABLE] =
			lp_an_able_reg; // (R15)
	end

	// Read data is chosen in the setup cycle and registered, so prdata
	// is stable from a flop for the whole access phase.
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (setup_phase && !pwrite && setup_hit) begin
			case (setup_idx)
				an_status_pkg::PARTNER_IDX:
					rdata_next = low_half(partner_view); // (R1) (R7)
				an_status_pkg::EXPANSION_IDX:
					rdata_next = low_half(expansion_view);
				an_status_pkg::OVERRIDE_IDX:
					rdata_next = low_half(override_reg);
				an_status_pkg::IRQ_STATUS_IDX:
					rdata_next = irq_word(irq_status);
				an_status_pkg::IRQ_MASK_IDX:
					rdata_next = irq_word(irq_mask_reg);
				default:
					rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// One wait-free access: pready rises for the cycle after setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	// The error is decided at setup so that it stands beside pready.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup_phase & ~setup_hit;
		end
	end

	// The word chosen at setup is captured for the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= rdata_next;
		end
	end

	// Side effects act only at the completing edge of a clean access.
	assign partner_cw_we = override_on & strobe_for(wr_done, pslverr,
		acc_idx, an_status_pkg::PARTNER_IDX); // (R9)
	assign rsvd_we       = override_on & strobe_for(wr_done, pslverr,
		acc_idx, an_status_pkg::EXPANSION_IDX); // (R9)
	assign override_we   = strobe_for(wr_done, pslverr, acc_idx,
		an_status_pkg::OVERRIDE_IDX);
	assign mask_we       = strobe_for(wr_done, pslverr, acc_idx,
		an_status_pkg::IRQ_MASK_IDX);
	assign exp_read      = strobe_for(rd_done, pslverr, acc_idx,
		an_status_pkg::EXPANSION_IDX); // (R14)
	assign irq_read      = strobe_for(rd_done, pslverr, acc_idx,
		an_status_pkg::IRQ_STATUS_IDX);

	// The override bit itself is an ordinary writable control.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			override_reg <= an_status_pkg::OVR_RESET;
		end else if (override_we) begin
			override_reg <= {pwdata[an_status_pkg::OVR_BIT], 15'h0000};
		end
	end

	// Reserved expansion bits are held for the auxiliary functions but
	// never shown on a read; writes pass only under the override.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsvd_reg <= an_status_pkg::EX_RSVD_RESET;
		end else if (rsvd_we) begin
			rsvd_reg <= pwdata[an_status_pkg::EX_RSVD_LO
				+: an_status_pkg::EX_RSVD_W]; // (R9)
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_reserved <= an_status_pkg::EX_RSVD_RESET;
		end else begin
			aux_reserved <= rsvd_reg;
		end
	end

	// Stored partner word; the page flag is set on the same edge.
	page_capture u_page_capture (
		.pclk       (pclk),
		.presetn    (presetn),
		.page_valid (page_valid), // (R17)
		.page_word  (page_word),  // (R2) (R3)
		.cw_we      (partner_cw_we),
		.cw_data    (pwdata[15:0]),
		.word       (partner_word)
	);

	latch_high_flag u_page_rx (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (page_valid), // (R13) (R17)
		.clear   (exp_read),   // (R14)
		.q       (page_rx_flag)
	);

	// A fault and a read in one cycle leave the bit set.
	latch_high_flag u_pd_fault (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (pd_fault), // (R10)
		.clear   (exp_read),
		.q       (pd_fault_flag)
	);

	// Burst presence is a level from the arbitration logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lp_an_able_reg <= 1'b0;
		end else begin
			lp_an_able_reg <= flp_valid; // (R15)
		end
	end

	// Remote fault rising edge is an interrupt event.
	// Word and delayed copy reset alike, so no false edge follows reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem_fault_reg <= 1'b0;
		end else begin
			rem_fault_reg <= partner_word[an_status_pkg::PA_REM_FAULT];
		end
	end

	assign rem_fault_rise = partner_word[an_status_pkg::PA_REM_FAULT]
		& ~rem_fault_reg; // (R3)

	// Event vector of the interrupt status register, one bit per cause.
	assign irq_events[an_status_pkg::IRQ_PAGE_RX]   = page_valid;
	assign irq_events[an_status_pkg::IRQ_PD_FAULT]  = pd_fault;
	assign irq_events[an_status_pkg::IRQ_REM_FAULT] = rem_fault_rise;

	// Interrupt status, cleared by reading it; set wins over the clear.
	latch_high_flag u_irq_page (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (irq_events[an_status_pkg::IRQ_PAGE_RX]),
		.clear   (irq_read),
		.q       (irq_status[an_status_pkg::IRQ_PAGE_RX])
	);

	latch_high_flag u_irq_pd (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (irq_events[an_status_pkg::IRQ_PD_FAULT]),
		.clear   (irq_read),
		.q       (irq_status[an_status_pkg::IRQ_PD_FAULT])
	);

	latch_high_flag u_irq_rf (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (irq_events[an_status_pkg::IRQ_REM_FAULT]),
		.clear   (irq_read),
		.q       (irq_status[an_status_pkg::IRQ_REM_FAULT])
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= an_status_pkg::IRQ_MASK_RESET;
		end else if (mask_we) begin
			irq_mask_reg <= pwdata[2:0];
		end
	end

	// Masking only gates the output; the status bits latch regardless.
	assign irq_pending = |(irq_status & irq_mask_reg);

	// The output lags status by one cycle so it comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_pending;
		end
	end

endmodule : autoneg_partner_status_regs

// [bench/an_link_partner.sv]
// Behavioural remote link partner that hands received pages to the block.
// Assumes the bench asks for each page with a one-cycle go strobe.
module an_link_partner (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Bench control
	input  wire logic        go,
	input  wire logic        active,
	input  wire logic [15:0] word,
	// Received page
	output logic             page_valid,
	output logic             flp_valid,
	output logic      [15:0] page_word
);
	// The word flips between pages, so a stale value is never trusted.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_valid <= 1'b0;
			flp_valid  <= 1'b0;
			page_word  <= 16'h0000;
		end else begin
			page_valid <= go;
			flp_valid  <= active;
			page_word  <= go ? word : ~page_word;
		end
	end
endmodule : an_link_partner

// [bench/an_status_chk.sv]
// Assertions on the partner ability and expansion registers.
// Sees only the top-level ports and is bound below.
module an_status_chk (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Core side and outputs
	input wire logic        page_valid,
	input wire logic        pd_fault,
	input wire logic        flp_valid,
	input wire logic        irq,
	input wire logic [15:0] page_word,
	input wire logic [10:0] aux_reserved
);
	logic [15:0] lw;
	logic        rd5;
	logic        rdx;
	logic        pg_seen;
	logic        pd_seen;
	assign rd5 = psel && penable && pready && !pwrite && paddr == 12'h014;
	assign rdx = psel && penable && pready && !pwrite && paddr == 12'h018;
	// Shadow of the last stored page; selector bits may be overridden.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lw <= 16'h0000;
		else if (page_valid)
			lw <= page_word;
	end
	// Reference latches: an event sets, a read of the expansion register
	// clears, and a set in the same cycle wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg_seen <= 1'b0;
			pd_seen <= 1'b0;
		end else begin
			pg_seen <= page_valid | (pg_seen & ~rdx);
			pd_seen <= pd_fault | (pd_seen & ~rdx);
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PA_WORD:
	assert property (rd5 && !$past(page_valid) |->
		prdata[31:4] == {16'h0000, lw[15:4] & 12'hE3F}) else $error("word");
	AST_EX_RSVD:
	assert property (rdx |-> prdata[31:5] == 27'h0) else $error("rsvd");
	AST_NP_ABLE:
	assert property (rdx |-> prdata[2]) else $error("np able");
	AST_LP_NP:
	assert property (rdx && !$past(page_valid) |-> prdata[3] == lw[15])
		else $error("lp np");
	AST_PG_SET:
	assert property (rdx |-> prdata[1] == $past(pg_seen))
		else $error("page set");
	AST_RD_CLR:
	assert property ((rdx && !page_valid && !pd_fault)
		##1 (!page_valid && !pd_fault) ##2 rdx |->
		!prdata[1] && !prdata[4]) else $error("read clear");
	AST_PD_SET:
	assert property (rdx |-> prdata[4] == $past(pd_seen))
		else $error("pd set");
	AST_FLP:
	assert property (rdx |-> prdata[0] == $past(flp_valid, 2))
		else $error("flp");
	cover property (rdx && prdata[1]);
	cover property (rdx && prdata[4]);
	cover property (irq);
endmodule : an_status_chk

bind autoneg_partner_status_regs an_status_chk chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.page_valid, .pd_fault, .flp_valid, .irq, .page_word, .aux_reserved);

// [bench/autoneg_partner_status_regs_test.sv]
// Self-checking bench for the partner ability and expansion registers.
// Drives APB and a link partner model from one 100 MHz clock.
module autoneg_partner_status_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pd_fault = 1'b0, go = 1'b0, active = 1'b0;
	logic        pready, pslverr, page_valid, flp_valid, irq, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, seed = 32'h0000000F, prdata, rd, w;
	logic [15:0] word = 16'h0000, page_word;
	logic [10:0] aux_reserved;
	int          n_mismatch = 0, num_checks = 0;

	autoneg_partner_status_regs DUT (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .page_valid,
		.page_word, .pd_fault, .flp_valid, .aux_reserved, .irq);
	an_link_partner lp (.pclk, .presetn, .go, .active, .word,
		.page_valid, .page_word, .flp_valid);

	initial begin
		forever #5 pclk = ~pclk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic [31:0] ex(logic [15:0] v, logic p, d, f);
		return {27'h0, d, v[15], 1'b1, p, f};
	endfunction : ex

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t saw %h want %h", $time, s, e);
		end
	endtask : chk

	task automatic apb(input logic wr, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			n_mismatch++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic page(input logic [15:0] v);
		word <= v;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : page

	task automatic pulse_pd();
		pd_fault <= 1'b1;
		@(posedge pclk);
		pd_fault <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : pulse_pd

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 12'h018, 0);
		chk(rd, 32'h00000004);
		apb(0, 12'h014, 0);
		chk(rd, 32'h00000000);
		apb(0, 12'h100, 0);
		chk({31'h0, err}, 32'h1);
		apb(0, 12'h015, 0);
		chk({31'h0, err}, 32'h1);
		$display("reset test done");
		active <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			w = rnd();
			// The first two pages carry both defined selector codes.
			if (i < 2)
				w[4:0] = 5'(i + 1);
			page(w[15:0]);
			apb(0, 12'h014, 0);
			chk(rd, {16'h0, w[15:0] & 16'hE3FF});
			apb(0, 12'h018, 0);
			chk(rd, ex(w[15:0], 1'b1, 1'b0, 1'b1));
			apb(0, 12'h018, 0);
			chk(rd, ex(w[15:0], 1'b0, 1'b0, 1'b1));
		end
		$display("page test done");
		apb(1, 12'h014, 32'h0000000F);
		apb(0, 12'h014, 0);
		chk(rd, {16'h0, w[15:0] & 16'hE3FF});
		apb(1, 12'h040, 32'h00008000);
		apb(1, 12'h014, 32'h00000005);
		apb(0, 12'h014, 0);
		chk(rd, {16'h0, w[15:0] & 16'hE3F0 | 16'h0005});
		apb(1, 12'h018, 32'h0000FFE0);
		@(posedge pclk);
		chk({21'h0, aux_reserved}, 32'h000007FF);
		apb(0, 12'h018, 0);
		chk(rd, ex(w[15:0], 1'b0, 1'b0, 1'b1));
		apb(1, 12'h018, 0);
		apb(1, 12'h040, 0);
		apb(1, 12'h018, 32'h0000FFE0);
		@(posedge pclk);
		chk({21'h0, aux_reserved}, 32'h00000000);
		$display("override test done");
		apb(0, 12'h080, 0);
		apb(1, 12'h084, 32'h00000002);
		pulse_pd();
		chk({31'h0, irq}, 32'h1);
		apb(0, 12'h018, 0);
		chk(rd, ex(w[15:0], 1'b0, 1'b1, 1'b1));
		apb(0, 12'h018, 0);
		chk(rd, ex(w[15:0], 1'b0, 1'b0, 1'b1));
		apb(0, 12'h080, 0);
		chk(rd, 32'h00000002);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1, 12'h084, 0);
		pulse_pd();
		chk({31'h0, irq}, 32'h0);
		$display("interrupt test done");
		end_sim();
	end
endmodule : autoneg_partner_status_regs_test
